// [logic/pulse_period_freq_pkg.sv]
// Purpose: constants, types and register layout for the pulse, period and frequency counter
// Assumes: 25 MHz CLK, APB register access with 32-bit words
// Notes: every register takes one aligned word; bits not listed read as zero
package pulse_period_freq_pkg;
  // clocking and slow timebase
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TB_SLOW_HZ = 100_000;
  localparam int unsigned TB_SLOW_DIV = CLK_HZ / TB_SLOW_HZ;
  localparam logic [7:0] TB_SLOW_LAST = 8'(TB_SLOW_DIV - 1);

  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] DIVN_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  localparam logic [11:0] HIGH_OFF = 12'h00c;
  localparam logic [11:0] LOW_OFF = 12'h010;

  // control field positions
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_FIRST_BIT = 8;
  localparam int CTRL_SEMI_FIRST_BIT = 9;
  localparam int CTRL_AVG_BIT = 10;
  localparam int CTRL_SRC_SEL_LSB = 12;
  localparam int CTRL_SRC_FALL_BIT = 14;
  localparam int CTRL_GATE_PAIR_BIT = 15;
  localparam int CTRL_SC_FALL_BIT = 16;

  // status field positions
  localparam int STATUS_OVR_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int STATUS_LEVEL_LSB = 8;

  // counter fifo
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [PTR_W:0] FIFO_FULL_LEVEL = 4'h8;

  localparam logic [31:0] DIVN_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    MODE_SINGLE_PULSE, MODE_BUF_PULSE, MODE_SC_PULSE, MODE_SINGLE_SEMI,
    MODE_BUF_SEMI, MODE_PERIOD, MODE_WIDTH, MODE_SC_FREQ
  } mode_type;

  typedef enum logic [1:0] {SRC_PIN, SRC_TB_SLOW, SRC_TB_MID, SRC_TB_FAST} src_sel_type;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_START, ST_MEASURE, ST_DONE} state_type;

  typedef struct packed {
    logic sc_falling;
    logic gate_from_pair;
    logic src_falling;
    src_sel_type src_sel;
    logic freq_average_enable;
    logic semi_interval_first_select;
    logic first_interval_select;
    mode_type mode;
  } ctrl_type;

  // averaging on by default for buffered frequency
  localparam ctrl_type CTRL_RESET = '{sc_falling: 1'b0, gate_from_pair: 1'b0, src_falling: 1'b0,
    src_sel: SRC_PIN, freq_average_enable: 1'b1, semi_interval_first_select: 1'b0,
    first_interval_select: 1'b0, mode: MODE_SINGLE_PULSE};
endpackage : pulse_period_freq_pkg

// [logic/pulse_period_freq_counter.sv]
// Purpose: one measuring counter with its pair divider, counter fifo and stream output
// Assumes: all pin inputs asynchronous to CLK; APB master per the AMBA rules
// Notes: pin signals must stay stable at least two CLK periods per level to be seen
//
// Local design decisions: the APB register port and the placing of the registers.

// Summary of operation
// - single pulse mode takes a high-interval count and a low-interval count.
// - buffered pulse mode pushes the count into the fifo at every gate edge.
// - after arming, nothing is counted until the chosen starting gate edge, or the sample edge when averaging.
// - starting-edge setting picks high or low interval as first captured value.
// - each sample clock edge stores high and low counts of last finished pulse.
// - no complete pulse between two sample clock edges raises overrun.
// - semi-period is the span between any two consecutive gate edges after arming.
// - source edges of the chosen polarity are counted between bounding gate edges.
// - single semi-period measurement is a single width measurement.
// - buffered semi-period stores one count per gate edge, high or low interval.
// - pulse and semi-period share capture logic; only grouping differs.
// - sample clock capture serves pulse mode, never semi-period mode.
// - one-counter frequency measures one gate period against a known timebase.
// - counters pair as 0 with 1 and 2 with 3 for two-counter methods.
// - known-width gate from pair or function terminal; signal under test is source.
// - pair counter makes one pulse of N source periods to gate the measurer.
// - averaging frequency captures fx cycles and timebase ticks per sample period.
// - averaging enable chooses averaged or single period; defaults to averaging.
// - non-averaging captures the last period completed before the sample edge.
// - fifo values stream out to host over a continuous valid/ready path.
// - armed with gate active, wait for the next transition into active.
module pulse_period_freq_counter
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // measurement pins; GATE may carry a known-width pulse from a function terminal
  input wire logic GATE,
  input wire logic SRC,
  input wire logic DIV_SRC,
  input wire logic SAMPLE_CLK,
  input wire logic TB_MID,
  input wire logic TB_FAST,
  // pair counter output, the gate of the partner counter
  output logic PAIR_OUT,
  // stream to host memory
  output logic [31:0] STREAM_DATA,
  output logic STREAM_VALID,
  input wire logic STREAM_READY
);
  import pulse_period_freq_pkg::*;
  function automatic logic edge_of(input logic cur, input logic prev, input logic falling);
    edge_of = (cur != prev) && (cur == ~falling);
  endfunction : edge_of
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      strb_merge[8*i +: 8] = strb[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : strb_merge
  // pin synchronisers: gate, src, div_src, sample clk, mid, fast
  logic [5:0] pin_meta_q, pin_sync_q, pin_prev_q;
  logic [7:0] tb_cnt_q;
  logic tb_tick_q;
  ctrl_type ctrl_q;
  logic [31:0] ctrl_word, divn_q, hi_q, lo_q, pair_hi_q, pair_lo_q, count_q, emb_q;
  logic [31:0] pend_q, out_data_q, div_cnt_q, rdata_d;
  state_type state_q;
  logic phase_q, pulse_new_q, pend_valid_q, ovr_q, done_q, pair_out_q, div_run_q, out_valid_q;
  logic [31:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [PTR_W:0] level_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
      pin_prev_q <= 6'h00;
    end else begin
      pin_meta_q <= {TB_FAST, TB_MID, SAMPLE_CLK, DIV_SRC, SRC, GATE};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end
  // slow timebase as a one-cycle enable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tb_cnt_q <= 8'h00;
      tb_tick_q <= 1'b0;
    end else begin
      tb_tick_q <= (tb_cnt_q == TB_SLOW_LAST);
      tb_cnt_q <= (tb_cnt_q == TB_SLOW_LAST) ? 8'h00 : tb_cnt_q + 8'h01;
    end
  end
  // apb decode
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire hit_ctrl = (PADDR == CTRL_OFF);
  wire hit_divn = (PADDR == DIVN_OFF);
  wire hit_status = (PADDR == STATUS_OFF);
  wire hit_any = hit_ctrl | hit_divn | hit_status | (PADDR == HIGH_OFF) | (PADDR == LOW_OFF);
  wire arm = apb_wr & hit_ctrl & PSTRB[0] & PWDATA[CTRL_ARM_BIT];
  wire ovr_clear = apb_wr & hit_status & PSTRB[0] & PWDATA[STATUS_OVR_BIT];
  wire [31:0] ctrl_wdata = strb_merge(ctrl_word, PWDATA, PSTRB);
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_MODE_LSB +: 3] = ctrl_q.mode;
    ctrl_word[CTRL_FIRST_BIT] = ctrl_q.first_interval_select;
    ctrl_word[CTRL_SEMI_FIRST_BIT] = ctrl_q.semi_interval_first_select;
    ctrl_word[CTRL_AVG_BIT] = ctrl_q.freq_average_enable;
    ctrl_word[CTRL_SRC_SEL_LSB +: 2] = ctrl_q.src_sel;
    ctrl_word[CTRL_SRC_FALL_BIT] = ctrl_q.src_falling;
    ctrl_word[CTRL_GATE_PAIR_BIT] = ctrl_q.gate_from_pair;
    ctrl_word[CTRL_SC_FALL_BIT] = ctrl_q.sc_falling;
  end
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (PADDR)
      CTRL_OFF: rdata_d = ctrl_word;
      DIVN_OFF: rdata_d = divn_q;
      STATUS_OFF: begin
        rdata_d[STATUS_OVR_BIT] = ovr_q;
        rdata_d[STATUS_DONE_BIT] = done_q;
        rdata_d[STATUS_BUSY_BIT] = (state_q == ST_WAIT_START) || (state_q == ST_MEASURE);
        rdata_d[STATUS_LEVEL_LSB +: PTR_W+1] = level_q;
      end
      HIGH_OFF: rdata_d = hi_q;
      LOW_OFF: rdata_d = lo_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  // read data is latched in setup so the access phase answers at once
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
      ctrl_q <= CTRL_RESET;
      divn_q <= DIVN_RESET;
    end else begin
      if (apb_setup) PRDATA <= rdata_d;
      if (apb_wr && hit_ctrl) begin
        ctrl_q.mode <= mode_type'(ctrl_wdata[CTRL_MODE_LSB +: 3]);
        ctrl_q.first_interval_select <= ctrl_wdata[CTRL_FIRST_BIT];
        ctrl_q.semi_interval_first_select <= ctrl_wdata[CTRL_SEMI_FIRST_BIT];
        ctrl_q.freq_average_enable <= ctrl_wdata[CTRL_AVG_BIT];
        ctrl_q.src_sel <= src_sel_type'(ctrl_wdata[CTRL_SRC_SEL_LSB +: 2]);
        ctrl_q.src_falling <= ctrl_wdata[CTRL_SRC_FALL_BIT];
        ctrl_q.gate_from_pair <= ctrl_wdata[CTRL_GATE_PAIR_BIT];
        ctrl_q.sc_falling <= ctrl_wdata[CTRL_SC_FALL_BIT];
      end
      if (apb_wr && hit_divn) divn_q <= strb_merge(divn_q, PWDATA, PSTRB);
    end
  end
  // pair divider pulse
  // high from the first DIV_SRC rising edge after arming, low after N periods
  wire div_ev = pin_sync_q[2] & ~pin_prev_q[2];
  wire [31:0] div_last = (divn_q == 32'h0000_0000) ? 32'h0000_0000 : divn_q - 32'h0000_0001;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pair_out_q <= 1'b0;
      div_run_q <= 1'b0;
      div_cnt_q <= 32'h0000_0000;
    end else if (arm) begin
      pair_out_q <= 1'b0;
      div_run_q <= 1'b1;
      div_cnt_q <= 32'h0000_0000;
    end else if (div_run_q && div_ev) begin
      if (!pair_out_q) begin
        pair_out_q <= 1'b1;
      end else if (div_cnt_q == div_last) begin
        pair_out_q <= 1'b0;
        div_run_q <= 1'b0;
      end else begin
        div_cnt_q <= div_cnt_q + 32'h0000_0001;
      end
    end
  end
  assign PAIR_OUT = pair_out_q;
  // gate from pin or partner pulse
  wire gate_cur = ctrl_q.gate_from_pair ? pair_out_q : pin_sync_q[0];
  logic gate_prev_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) gate_prev_q <= 1'b0;
    else gate_prev_q <= gate_cur;
  end
  wire g_rise = gate_cur & ~gate_prev_q;
  wire g_fall = ~gate_cur & gate_prev_q;
  wire g_edge = g_rise | g_fall;
  logic src_cur, src_prev;
  always_comb begin
    case (ctrl_q.src_sel)
      SRC_TB_MID: begin src_cur = pin_sync_q[4]; src_prev = pin_prev_q[4]; end
      SRC_TB_FAST: begin src_cur = pin_sync_q[5]; src_prev = pin_prev_q[5]; end
      default: begin src_cur = pin_sync_q[1]; src_prev = pin_prev_q[1]; end
    endcase
  end
  wire src_ev = (ctrl_q.src_sel == SRC_TB_SLOW) ? tb_tick_q : edge_of(src_cur, src_prev, ctrl_q.src_falling);
  wire sc_ev = edge_of(pin_sync_q[3], pin_prev_q[3], ctrl_q.sc_falling);
  // mode decode
  wire m_semi = (ctrl_q.mode == MODE_SINGLE_SEMI) || (ctrl_q.mode == MODE_BUF_SEMI);
  wire m_buf = (ctrl_q.mode == MODE_BUF_PULSE) || (ctrl_q.mode == MODE_BUF_SEMI);
  wire m_scp = (ctrl_q.mode == MODE_SC_PULSE);
  wire m_scf = (ctrl_q.mode == MODE_SC_FREQ);
  wire m_avg = m_scf & ctrl_q.freq_average_enable;
  wire m_one = (ctrl_q.mode == MODE_SINGLE_SEMI) || (ctrl_q.mode == MODE_WIDTH);
  wire measuring = (state_q == ST_MEASURE);
  wire first_low = m_semi ? ctrl_q.semi_interval_first_select : ctrl_q.first_interval_select;
  // start on a transition into the measured level, or on a sample edge when averaging
  wire start_edge = m_avg ? sc_ev : ((first_low & ~m_scf & ctrl_q.mode != MODE_PERIOD) ? g_fall : g_rise);
  wire buf_push = measuring & m_buf & g_edge;
  // sample edge emits last finished pulse
  // sample capture exists only for pulse and frequency modes
  wire sc_push = measuring & sc_ev & ((m_scp | (m_scf & ~m_avg)) ? pulse_new_q : m_avg);
  wire push_req = buf_push | sc_push;
  wire [31:0] push_data = m_buf ? count_q : (m_avg ? emb_q : pair_hi_q);
  wire pend_set = sc_push & (m_scp | m_avg);
  wire [31:0] pend_d = m_scp ? pair_lo_q : count_q;
  // slow fx shows as an empty averaging window
  wire sc_miss = measuring & sc_ev & (((m_scp | (m_scf & ~m_avg)) & ~pulse_new_q) | (m_avg & (emb_q == 32'h0000_0000)));
  wire fifo_full = (level_q == FIFO_FULL_LEVEL);
  wire fifo_wr = (pend_valid_q | push_req) & ~fifo_full;
  wire [31:0] fifo_wdata = pend_valid_q ? pend_q : push_data;
  wire lost = ((pend_valid_q | push_req) & fifo_full) | (pend_valid_q & push_req);
  wire fifo_rd = (level_q != '0) & (~out_valid_q | STREAM_READY);
  wire [31:0] next_hi = g_fall ? count_q : hi_q;
  wire [31:0] next_lo = g_rise ? count_q : lo_q;
  wire [31:0] count_restart = src_ev ? 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      count_q <= 32'h0000_0000;
      emb_q <= 32'h0000_0000;
      hi_q <= 32'h0000_0000;
      lo_q <= 32'h0000_0000;
      pair_hi_q <= 32'h0000_0000;
      pair_lo_q <= 32'h0000_0000;
      phase_q <= 1'b0;
      pulse_new_q <= 1'b0;
      done_q <= 1'b0;
    end else if (arm) begin
      // arming clears count and capture state
      state_q <= ST_WAIT_START;
      count_q <= 32'h0000_0000;
      emb_q <= 32'h0000_0000;
      phase_q <= 1'b0;
      pulse_new_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        ST_WAIT_START: begin
          if (start_edge) state_q <= ST_MEASURE;
        end
        ST_MEASURE: begin
          // count source edges inside the interval
          count_q <= count_q + (src_ev ? 32'h0000_0001 : 32'h0000_0000);
          if (m_avg && g_rise) emb_q <= emb_q + 32'h0000_0001;
          if (m_avg && sc_ev) begin
            count_q <= count_restart;
            emb_q <= g_rise ? 32'h0000_0001 : 32'h0000_0000;
          end
          if (m_scp && sc_ev) pulse_new_q <= 1'b0;
          // period just before the sample edge
          if (m_scf && !m_avg && g_rise) begin
            pair_hi_q <= count_q;
            pulse_new_q <= 1'b1;
            count_q <= count_restart;
          end
          if (g_edge && !m_scf) begin
            count_q <= count_restart;
            hi_q <= next_hi;
            lo_q <= next_lo;
            phase_q <= ~phase_q;
            case (ctrl_q.mode)
              MODE_SINGLE_PULSE: if (phase_q) begin
                state_q <= ST_DONE;
                done_q <= 1'b1;
              end
              // any two consecutive edges bound it
              MODE_SINGLE_SEMI, MODE_WIDTH: begin
                state_q <= ST_DONE;
                done_q <= 1'b1;
              end
              // one full period from rise to rise
              MODE_PERIOD: if (g_rise) begin
                hi_q <= count_q;
                state_q <= ST_DONE;
                done_q <= 1'b1;
              end else begin
                count_q <= count_q + (src_ev ? 32'h0000_0001 : 32'h0000_0000);
                hi_q <= hi_q;
                lo_q <= lo_q;
              end
              MODE_SC_PULSE: if (phase_q) begin
                pair_hi_q <= next_hi;
                pair_lo_q <= next_lo;
                pulse_new_q <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
  end
  // overrun: a new error wins over a same-cycle clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ovr_q <= 1'b0;
    else if (sc_miss || lost) ovr_q <= 1'b1;
    else if (ovr_clear) ovr_q <= 1'b0;
  end
  // pulse pairs go out as two consecutive words
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_valid_q <= 1'b0;
      pend_q <= 32'h0000_0000;
    end else if (arm) begin
      pend_valid_q <= 1'b0;
    end else begin
      pend_valid_q <= pend_set;
      if (pend_set) pend_q <= pend_d;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= 32'h0000_0000;
    end else begin
      if (fifo_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (fifo_rd) rd_ptr_q <= rd_ptr_q + 1'b1;
      level_q <= level_q + (fifo_wr ? 4'h1 : 4'h0) - (fifo_rd ? 4'h1 : 4'h0);
      if (fifo_rd) begin
        out_data_q <= mem_q[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (STREAM_READY) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (fifo_wr) mem_q[wr_ptr_q] <= fifo_wdata;
  end

  assign STREAM_DATA = out_data_q;
  assign STREAM_VALID = out_valid_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  chk_arm_clears_count: assert property (arm |=> count_q == 32'h0000_0000 && state_q == ST_WAIT_START)
    else $error("arm did not clear the count");
  chk_wait_holds_count: assert property (state_q == ST_WAIT_START && !arm |=> $stable(count_q))
    else $error("count moved before starting edge");
  chk_buf_edge_push: assert property (measuring && m_buf && g_edge && !fifo_full && !pend_valid_q |-> fifo_wr)
    else $error("gate edge in buffered mode not pushed");
  chk_sc_miss_ovr: assert property (measuring && m_scp && sc_ev && !pulse_new_q && !arm |=> ovr_q)
    else $error("missing pulse did not flag overrun");
  chk_src_count_step: assert property (measuring && !m_scf && src_ev && !g_edge && !arm
    |=> count_q == $past(count_q) + 32'h0000_0001)
    else $error("source edge not counted");
  chk_single_width_done: assert property (measuring && m_one && g_edge && !arm |=> state_q == ST_DONE && done_q)
    else $error("single width did not finish at the closing edge");
  chk_sc_pair_words: assert property (sc_push && m_scp && !arm |=> pend_valid_q ##0 pend_q == $past(pair_lo_q))
    else $error("low ticks of pair not queued after high ticks");
  chk_avg_pushes: assert property (measuring && m_avg && sc_ev |-> push_req)
    else $error("averaging window not captured at sample edge");
  chk_pair_pulse_ends: assert property (pair_out_q && div_ev && div_cnt_q == div_last && !arm |=> !pair_out_q)
    else $error("pair pulse longer than N periods");
  chk_stream_hold: assert property (STREAM_VALID && !STREAM_READY |=> STREAM_VALID && $stable(STREAM_DATA))
    else $error("stream word dropped under back-pressure");
endmodule : pulse_period_freq_counter

// [testbench/stream_sink.sv]
// Purpose: far side model, known source timebase and host stream sink
// Assumes: SRC levels last two CLK so the pin synchroniser sees them
// Notes: ready drops one cycle in four so the stream output must hold
module stream_sink (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // source timebase
  output logic SRC,
  // stream from the counter
  input wire logic [31:0] STREAM_DATA,
  input wire logic STREAM_VALID,
  output logic STREAM_READY
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_q;
  logic [31:0] got [0:15];
  int n_got;
  assign SRC = ph_q[1];
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ph_q <= 2'h0;
      STREAM_READY <= 1'b0;
      n_got <= 0;
    end else begin
      ph_q <= ph_q + 2'h1;
      STREAM_READY <= (ph_q != 2'h2);
      if (STREAM_VALID && STREAM_READY) begin
        got[n_got[3:0]] <= STREAM_DATA;
        n_got <= n_got + 1;
      end
    end
  end
endmodule : stream_sink

// [testbench/test_pulse_period_freq_counter.sv]
// Purpose: self-checking bench for the pulse, period and frequency counter
// Assumes: gate edges fall one CLK after a source rise, so no count is ambiguous
// Notes: source rises every 4 CLK; interval of n CLK holds n/4 rises
module test_pulse_period_freq_counter;
  import pulse_period_freq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL, PENABLE, PWRITE, GATE, SAMPLE_CLK, err;
  logic PREADY, PSLVERR, PAIR_OUT, STREAM_VALID, STREAM_READY, SRC;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, STREAM_DATA, rd;
  int fails = 0;
  int tests_run = 0;
  int base;
  always #20 CLK = ~CLK;
  pulse_period_freq_counter i_pulse_period_freq_counter (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .GATE(GATE), .SRC(SRC), .DIV_SRC(SRC),
    .SAMPLE_CLK(SAMPLE_CLK), .TB_MID(1'b0), .TB_FAST(1'b0), .PAIR_OUT(PAIR_OUT),
    .STREAM_DATA(STREAM_DATA), .STREAM_VALID(STREAM_VALID), .STREAM_READY(STREAM_READY));
  stream_sink i_stream_sink (.CLK(CLK), .RSTN(RSTN), .SRC(SRC), .STREAM_DATA(STREAM_DATA),
    .STREAM_VALID(STREAM_VALID), .STREAM_READY(STREAM_READY));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50) begin
      fails++;
      stop_test();
    end
  endtask : apb
  task automatic align();
    @(posedge SRC);
    @(posedge CLK);
  endtask : align
  task automatic gate_for(input logic v, input int n);
    GATE <= v;
    cyc(n);
  endtask : gate_for
  task automatic wait_done();
    int k;
    for (k = 0; k < 100; k++) begin
      apb(1'b0, STATUS_OFF, 32'h0);
      if (rd[STATUS_DONE_BIT] === 1'b1) break;
    end
    if (k >= 100) begin
      fails++;
      stop_test();
    end
  endtask : wait_done
  task automatic test_regs();
    apb(1'b0, CTRL_OFF, 32'h0);
    check(rd, 32'h0000_0400, "ctrl reset");
    apb(1'b0, DIVN_OFF, 32'h0);
    check(rd, 32'h0000_0001, "divn reset");
    apb(1'b0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, DIVN_OFF, 32'h0000_0005);
    apb(1'b0, DIVN_OFF, 32'h0);
    check(rd, 32'h0000_0005, "divn write");
    $display("test regs done");
  endtask : test_regs
  task automatic test_single();
    apb(1'b1, CTRL_OFF, 32'h0000_0401);
    align();
    gate_for(1'b1, 40);
    gate_for(1'b0, 32);
    gate_for(1'b1, 8);
    wait_done();
    apb(1'b0, HIGH_OFF, 32'h0);
    check(rd, 32'h0000_000a, "single high ticks");
    apb(1'b0, LOW_OFF, 32'h0);
    check(rd, 32'h0000_0008, "single low ticks");
    $display("test single done");
  endtask : test_single
  task automatic test_buffered();
    // armed while gate high, low interval first
    apb(1'b1, CTRL_OFF, 32'h0000_0511);
    base = i_stream_sink.n_got;
    align();
    gate_for(1'b0, 20);
    gate_for(1'b1, 32);
    gate_for(1'b0, 24);
    gate_for(1'b1, 8);
    cyc(30);
    check(32'(i_stream_sink.n_got - base), 32'h3, "word count");
    check(i_stream_sink.got[base[3:0]], 32'h5, "first low");
    check(i_stream_sink.got[4'(base + 1)], 32'h8, "then high");
    check(i_stream_sink.got[4'(base + 2)], 32'h6, "then low");
    $display("test buffered done");
  endtask : test_buffered
  task automatic test_overrun();
    // one full pulse, then gate held high so the second sample edge finds none
    apb(1'b1, CTRL_OFF, 32'h0000_0421);
    base = i_stream_sink.n_got;
    align();
    gate_for(1'b0, 8);
    gate_for(1'b1, 20);
    gate_for(1'b0, 12);
    gate_for(1'b1, 8);
    repeat (2) begin
      SAMPLE_CLK <= 1'b1;
      cyc(8);
      SAMPLE_CLK <= 1'b0;
      cyc(8);
    end
    check(32'(i_stream_sink.n_got - base), 32'h2, "sc word count");
    check(i_stream_sink.got[base[3:0]], 32'h5, "sc high ticks");
    check(i_stream_sink.got[4'(base + 1)], 32'h3, "sc low ticks");
    apb(1'b0, STATUS_OFF, 32'h0);
    check({31'h0, rd[STATUS_OVR_BIT]}, 32'h1, "overrun set");
    apb(1'b1, STATUS_OFF, 32'h0000_0001);
    apb(1'b0, STATUS_OFF, 32'h0);
    check({31'h0, rd[STATUS_OVR_BIT]}, 32'h0, "overrun clear");
    $display("test overrun done");
  endtask : test_overrun
  task automatic test_period();
    apb(1'b1, CTRL_OFF, 32'h0000_0451);
    align();
    gate_for(1'b0, 24);
    gate_for(1'b1, 24);
    gate_for(1'b0, 24);
    gate_for(1'b1, 8);
    wait_done();
    apb(1'b0, HIGH_OFF, 32'h0);
    check(rd, 32'h0000_000c, "period ticks");
    $display("test period done");
  endtask : test_period
  task automatic test_pair();
    // divider n is 5 from test_regs; source period 4 clk
    int hi = 0;
    apb(1'b1, CTRL_OFF, 32'h0000_8461);
    repeat (60) begin
      @(negedge CLK);
      if (PAIR_OUT === 1'b1) hi++;
    end
    check(32'(hi), 32'h14, "pair pulse cycles");
    wait_done();
    apb(1'b0, HIGH_OFF, 32'h0);
    check(rd, 32'h5, "pair width ticks");
    $display("test pair done");
  endtask : test_pair
  task automatic test_semi();
    // semi first select picks low; pulse first select left high
    apb(1'b1, CTRL_OFF, 32'h0000_0641);
    base = i_stream_sink.n_got;
    align();
    gate_for(1'b0, 12);
    gate_for(1'b1, 16);
    gate_for(1'b0, 8);
    gate_for(1'b1, 28);
    check(32'(i_stream_sink.n_got - base), 32'h3, "semi word count");
    check(i_stream_sink.got[base[3:0]], 32'h3, "semi first low");
    check(i_stream_sink.got[4'(base + 1)], 32'h4, "semi high");
    check(i_stream_sink.got[4'(base + 2)], 32'h2, "semi low");
    $display("test semi done");
  endtask : test_semi
  task automatic test_freq();
    // averaging on from reset; gate period 8 clk, sample period 32 clk
    apb(1'b1, CTRL_OFF, 32'h0000_0471);
    base = i_stream_sink.n_got;
    align();
    // measured gate four times the sample rate
    for (int i = 0; i < 24; i++) begin
      GATE <= i[0];
      SAMPLE_CLK <= i[2];
      cyc(4);
    end
    cyc(20);
    check(32'(i_stream_sink.n_got - base), 32'h4, "freq word count");
    check(i_stream_sink.got[base[3:0]], 32'h4, "fx cycles");
    check(i_stream_sink.got[4'(base + 1)], 32'h8, "timebase ticks");
    check(i_stream_sink.got[4'(base + 2)], 32'h4, "next fx cycles");
    $display("test freq done");
  endtask : test_freq
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    GATE = 1'b0;
    SAMPLE_CLK = 1'b0;
    cyc(20);
    RSTN <= 1'b1;
    test_regs();
    test_single();
    test_buffered();
    test_overrun();
    test_pair();
    test_semi();
    test_period();
    test_freq();
    stop_test();
  end
endmodule : test_pulse_period_freq_counter
